// ### core/osd_access_pkg.sv
package osd_access_pkg;
    // widths of the address, code and ornamentation paths
    localparam int ADDR_W  = 9;
    localparam int CODE_W  = 9;
    localparam int DATA_W  = 8;
    localparam int DEPTH   = 512;

    // register select codes presented with each strobe
    typedef enum logic [2:0] {
        SEL_ADDR_MSB = 3'h0,   // upper address bit
        SEL_ADDR_LOW = 3'h1,   // low 8 address bits, loads the pointer
        SEL_CODE_MSB = 3'h2,   // upper code bit
        SEL_CODE_LOW = 3'h3,   // low 8 code bits, commits or completes a read
        SEL_ORNAMENT = 3'h4    // ornamentation byte
    } reg_sel_t;

    // ornamentation byte layout; bit 3 is unused and reads zero
    localparam int ORN_BLUE       = 0;
    localparam int ORN_GREEN      = 1;
    localparam int ORN_RED        = 2;
    localparam int ORN_BLINK      = 4;
    localparam int ORN_UNDERLINE  = 5;
    localparam int ORN_SLANT      = 6;
    localparam int ORN_BACKGROUND = 7;
    localparam logic [DATA_W-1:0] ORN_MASK = 8'hF7;

    // reset values and small constants
    localparam logic [ADDR_W-1:0] ADDR_RST  = 9'h000;
    localparam logic [ADDR_W-1:0] ADDR_ONE  = 9'h001;
    localparam logic [DATA_W-1:0] DATA_RST  = 8'h00;
    localparam logic [CODE_W-1:0] CODE_RST  = 9'h000;
    localparam logic              BIT_RST   = 1'b0;
    localparam logic [6:0]        MSB_PAD   = 7'h00;
endpackage : osd_access_pkg

// ### core/osd_display_memory_access_port.sv
`timescale 1ns/1ps

// Operation
// - normal mode advances address after each low code byte or bank 0 ornament access
// - bank 0 code write commits nine bits
// - bank 0 ornament write commits and increments
// - bank 1 ornament written at once, pointer held; code write commits both
// - normal code read: upper bit, low byte, then increment
// - normal bank 0 ornament read increments
// - increments follow the mode, bank, direction matrix
// - rmw reads keep address, writes increment except bank 1 ornament
// - rmw bank 1 ornament written at once, pointer held until code write
// - missing upper code write reuses previous bit
module osd_display_memory_access_port
    import osd_access_pkg::*;
(
    input  wire logic                          clock,            // system clock
    input  wire logic                          rst,              // async reset
    input  wire logic                          rmw_mode_select,  // 1 read-modify-write
    input  wire logic                          bank_both_select, // 1 code and ornament
    input  wire logic                          access_direction, // 1 read, 0 write
    input  wire logic                          wr_en,            // cpu write strobe
    input  wire logic                          rd_en,            // cpu read strobe
    input  wire osd_access_pkg::reg_sel_t      reg_sel,          // register addressed
    input  wire logic [osd_access_pkg::DATA_W-1:0] wr_data,      // cpu write byte
    input  wire logic [osd_access_pkg::ADDR_W-1:0] disp_addr,    // display fetch address
    output logic [osd_access_pkg::DATA_W-1:0]  rd_data,          // cpu read byte
    output logic                               rd_valid,         // read answer pulse
    output logic [osd_access_pkg::ADDR_W-1:0]  cur_addr,         // access pointer
    output logic [osd_access_pkg::CODE_W-1:0]  disp_code,        // fetched code
    output logic [osd_access_pkg::DATA_W-1:0]  disp_orn          // fetched ornament
);
    import osd_access_pkg::*;

    // display memory, one code and one ornament per location
    logic [CODE_W-1:0] code_mem [DEPTH];  // character codes
    logic [DATA_W-1:0] orn_mem  [DEPTH];  // ornamentation bytes

    logic              addr_msb;          // staged upper address bit
    logic              code_msb;          // staged upper code bit, sticky
    logic [DATA_W-1:0] orn_hold;          // ornament captured on every ornament write
    logic              next_addr_msb;
    logic              next_code_msb;
    logic [DATA_W-1:0] next_orn_hold;
    logic [ADDR_W-1:0] next_cur_addr;
    logic [DATA_W-1:0] next_rd_data;
    logic              next_rd_valid;
    logic              code_we;           // commit code this cycle
    logic              orn_we;            // commit ornament this cycle
    logic [DATA_W-1:0] orn_wdata;         // ornament value to commit
    logic              do_write;          // accepted data-path write
    logic              do_read;           // accepted data-path read

    // increment matrix: rmw blocks reads, bank 1 blocks ornament access
    function automatic logic inc_due(input logic rmw, input logic bank,
                                     input logic is_read, input logic is_code);
        logic due;
        due = 1'b1;
        if (rmw && is_read) begin
            due = 1'b0;
        end else if (bank && !is_code) begin
            due = 1'b0;
        end
        return due;
    endfunction : inc_due

    // pointer step; plain 9-bit add so the top simply rolls over
    function automatic logic [ADDR_W-1:0] step(input logic [ADDR_W-1:0] a);
        return a + ADDR_ONE;
    endfunction : step

    // next-value logic for the access port
    always_comb begin
        next_addr_msb = addr_msb;
        next_code_msb = code_msb;
        next_orn_hold = orn_hold;
        next_cur_addr = cur_addr;
        next_rd_data  = rd_data;
        next_rd_valid = 1'b0;
        code_we       = 1'b0;
        orn_we        = 1'b0;
        orn_wdata     = wr_data & ORN_MASK;
        // data registers obey the direction bit; writes win over reads
        do_write = wr_en && !access_direction;
        do_read  = rd_en && !wr_en && access_direction;
        // address registers are open in either direction
        if (wr_en && reg_sel == SEL_ADDR_MSB) begin
            next_addr_msb = wr_data[0];
        end else if (wr_en && reg_sel == SEL_ADDR_LOW) begin
            next_cur_addr = {addr_msb, wr_data};
        end else if (do_write && reg_sel == SEL_CODE_MSB) begin
            next_code_msb = wr_data[0];
        end else if (do_write && reg_sel == SEL_CODE_LOW) begin
            // staged msb is reused if software skipped it
            code_we = 1'b1;
            if (bank_both_select) begin
                orn_we    = 1'b1;
                orn_wdata = orn_hold;
            end
            next_cur_addr = step(cur_addr);
        end else if (do_write && reg_sel == SEL_ORNAMENT) begin
            orn_we        = 1'b1;
            next_orn_hold = wr_data & ORN_MASK;
            if (inc_due(rmw_mode_select, bank_both_select, 1'b0, 1'b0)) begin
                next_cur_addr = step(cur_addr);
            end
        end else if (do_read && reg_sel == SEL_CODE_MSB) begin
            next_rd_data  = {MSB_PAD, code_mem[cur_addr][CODE_W-1]};
            next_rd_valid = 1'b1;
        end else if (do_read && reg_sel == SEL_CODE_LOW) begin
            next_rd_data  = code_mem[cur_addr][DATA_W-1:0];
            next_rd_valid = 1'b1;
            if (inc_due(rmw_mode_select, bank_both_select, 1'b1, 1'b1)) begin
                next_cur_addr = step(cur_addr);
            end
        end else if (do_read && reg_sel == SEL_ORNAMENT) begin
            next_rd_data  = orn_mem[cur_addr];
            next_rd_valid = 1'b1;
            if (inc_due(rmw_mode_select, bank_both_select, 1'b1, 1'b0)) begin
                next_cur_addr = step(cur_addr);
            end
        end else if (rd_en && !wr_en) begin
            // address fields and wrong-direction reads answer zero
            next_rd_data  = DATA_RST;
            next_rd_valid = 1'b1;
        end
    end

    // control state registers; a single-cycle update needs no spacing
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            addr_msb <= BIT_RST;
            code_msb <= BIT_RST;
            orn_hold <= DATA_RST;
            cur_addr <= ADDR_RST;
            rd_data  <= DATA_RST;
            rd_valid <= BIT_RST;
        end else begin
            addr_msb <= next_addr_msb;
            code_msb <= next_code_msb;
            orn_hold <= next_orn_hold;
            cur_addr <= next_cur_addr;
            rd_data  <= next_rd_data;
            rd_valid <= next_rd_valid;
        end
    end

    // memory write ports; no reset, contents are software defined
    always_ff @(posedge clock) begin
        if (code_we) begin
            code_mem[cur_addr] <= {code_msb, wr_data};
        end
        if (orn_we) begin
            orn_mem[cur_addr] <= orn_wdata;
        end
    end

    // display fetch port; a same-cycle write shows one cycle later
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            disp_code <= CODE_RST;
            disp_orn  <= DATA_RST;
        end else begin
            disp_code <= code_mem[disp_addr];
            disp_orn  <= orn_mem[disp_addr];
        end
    end

    // checks on pointer movement and committed data
    chk_code_wr_inc: assert property (@(posedge clock) disable iff (rst)
        (wr_en && !access_direction && reg_sel == SEL_CODE_LOW)
        |=> cur_addr == $past(cur_addr) + ADDR_ONE)
        else $error("code write did not advance pointer");

    chk_code_wr_data: assert property (@(posedge clock) disable iff (rst)
        (wr_en && !access_direction && reg_sel == SEL_CODE_LOW)
        |=> code_mem[$past(cur_addr)] == {$past(code_msb), $past(wr_data)})
        else $error("stored code differs from staged bits");

    chk_orn_bank0_inc: assert property (@(posedge clock) disable iff (rst)
        (wr_en && !access_direction && reg_sel == SEL_ORNAMENT && !bank_both_select)
        |=> cur_addr == $past(cur_addr) + ADDR_ONE
            && orn_mem[$past(cur_addr)] == ($past(wr_data) & ORN_MASK))
        else $error("bank 0 ornament write wrong");

    chk_orn_bank1_hold: assert property (@(posedge clock) disable iff (rst)
        (wr_en && !access_direction && reg_sel == SEL_ORNAMENT && bank_both_select)
        |=> $stable(cur_addr))
        else $error("bank 1 ornament write moved pointer");

    chk_both_commit: assert property (@(posedge clock) disable iff (rst)
        (wr_en && !access_direction && reg_sel == SEL_CODE_LOW && bank_both_select)
        |=> orn_mem[$past(cur_addr)] == $past(orn_hold))
        else $error("bank 1 code write lost ornament");

    chk_rmw_read_hold: assert property (@(posedge clock) disable iff (rst)
        (rd_en && !wr_en && access_direction && rmw_mode_select)
        |=> $stable(cur_addr) && rd_valid)
        else $error("rmw read moved pointer");

    chk_code_rd_inc: assert property (@(posedge clock) disable iff (rst)
        (rd_en && !wr_en && access_direction && !rmw_mode_select
         && reg_sel == SEL_CODE_LOW)
        |=> cur_addr == $past(cur_addr) + ADDR_ONE
            && rd_data == $past(code_mem[cur_addr][DATA_W-1:0]))
        else $error("normal code read wrong");

    chk_orn_rd_matrix: assert property (@(posedge clock) disable iff (rst)
        (rd_en && !wr_en && access_direction && !rmw_mode_select
         && reg_sel == SEL_ORNAMENT)
        |=> cur_addr == ($past(bank_both_select) ? $past(cur_addr)
                                                 : $past(cur_addr) + ADDR_ONE))
        else $error("ornament read increment wrong");

    chk_addr_wrap: assert property (@(posedge clock) disable iff (rst)
        ((&cur_addr) && wr_en && !access_direction
         && reg_sel == SEL_CODE_LOW) |=> cur_addr == ADDR_RST)
        else $error("pointer did not wrap");

    chk_addr_load: assert property (@(posedge clock) disable iff (rst)
        (wr_en && reg_sel == SEL_ADDR_LOW)
        |=> cur_addr == {$past(addr_msb), $past(wr_data)})
        else $error("address load wrong");

    // main scenarios
    cov_bank1_write: cover property (@(posedge clock) disable iff (rst)
        (wr_en && reg_sel == SEL_ORNAMENT && bank_both_select && !access_direction)
        ##[1:20] (wr_en && reg_sel == SEL_CODE_LOW && !access_direction));
    cov_rmw_cycle: cover property (@(posedge clock) disable iff (rst)
        (rd_en && rmw_mode_select && access_direction)
        ##[1:20] (wr_en && rmw_mode_select && !access_direction));
    cov_normal_read: cover property (@(posedge clock) disable iff (rst)
        (rd_en && reg_sel == SEL_CODE_LOW && access_direction && !rmw_mode_select));
    cov_wrap: cover property (@(posedge clock) disable iff (rst)
        (&cur_addr) ##1 (cur_addr == ADDR_RST));

endmodule : osd_display_memory_access_port

// ### verif/cpu_model.sv
`timescale 1ns/1ps

// cpu side: strobes launched on the falling edge, one cycle wide
module cpu_model
    import osd_access_pkg::*;
(
    input  wire logic                          clock,
    output logic                               rmw_mode_select,
    output logic                               bank_both_select,
    output logic                               access_direction,
    output logic                               wr_en,
    output logic                               rd_en,
    output osd_access_pkg::reg_sel_t           reg_sel,
    output logic [osd_access_pkg::DATA_W-1:0]  wr_data,
    input  wire logic [osd_access_pkg::DATA_W-1:0] rd_data,
    input  wire logic                          rd_valid
);
    initial begin
        {rmw_mode_select, bank_both_select, access_direction} = 3'h0;
        {wr_en, rd_en} = 2'h0;
        reg_sel = SEL_ADDR_MSB;
        wr_data = 8'h00;
    end

    // idle time between accesses, as a real cpu would leave
    task gap();
        repeat (2) @(negedge clock);
    endtask : gap

    // mode bits settle before any data access
    task mode(input logic m, input logic b, input logic d);
        @(negedge clock);
        rmw_mode_select  = m;
        bank_both_select = b;
        access_direction = d;
    endtask : mode

    task wr(input reg_sel_t s, input logic [7:0] d);
        @(negedge clock);
        wr_en   = 1'b1;
        reg_sel = s;
        wr_data = d;
        @(negedge clock);
        wr_en   = 1'b0;
        // released byte flips so a stale value cannot pass for data
        wr_data = ~d;
        gap();
    endtask : wr

    // answer is sampled in the one cycle that rd_valid stands
    task rd(input reg_sel_t s, output logic [7:0] d, output logic v);
        @(negedge clock);
        rd_en   = 1'b1;
        reg_sel = s;
        @(negedge clock);
        rd_en = 1'b0;
        d     = rd_data;
        v     = rd_valid;
        gap();
    endtask : rd

    // both strobes in one cycle: the write is taken, no read answer
    task both(input reg_sel_t s, input logic [7:0] d, output logic v);
        @(negedge clock);
        wr_en   = 1'b1;
        rd_en   = 1'b1;
        reg_sel = s;
        wr_data = d;
        @(negedge clock);
        wr_en   = 1'b0;
        rd_en   = 1'b0;
        wr_data = ~d;
        v       = rd_valid;
        gap();
    endtask : both

    // upper bit first, then low byte loads the pointer
    task set_addr(input logic [8:0] a);
        wr(SEL_ADDR_MSB, {7'h00, a[8]});
        wr(SEL_ADDR_LOW, a[7:0]);
    endtask : set_addr
endmodule : cpu_model

// ### verif/tb.sv
`timescale 1ns/1ps

module tb;
    import osd_access_pkg::*;
    logic        clock, rst, rmw_mode_select, bank_both_select, access_direction;
    logic        wr_en, rd_en, rd_valid;
    reg_sel_t    reg_sel;
    logic [7:0]  wr_data, rd_data, disp_orn;
    logic [8:0]  disp_addr, cur_addr, disp_code;
    int          fail_count = 0;
    int          n_tests = 0;

    osd_display_memory_access_port uut (.clock(clock), .rst(rst),
        .rmw_mode_select(rmw_mode_select), .bank_both_select(bank_both_select),
        .access_direction(access_direction), .wr_en(wr_en), .rd_en(rd_en),
        .reg_sel(reg_sel), .wr_data(wr_data), .disp_addr(disp_addr), .rd_data(rd_data),
        .rd_valid(rd_valid), .cur_addr(cur_addr), .disp_code(disp_code), .disp_orn(disp_orn));
    cpu_model cpu (.clock(clock), .rmw_mode_select(rmw_mode_select),
        .bank_both_select(bank_both_select), .access_direction(access_direction),
        .wr_en(wr_en), .rd_en(rd_en), .reg_sel(reg_sel), .wr_data(wr_data),
        .rd_data(rd_data), .rd_valid(rd_valid));

    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    task finish_test();
        if (fail_count == 0 && n_tests > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : finish_test

    task chk(input string n, input logic [8:0] e, input logic [8:0] s);
        n_tests++;
        if (s !== e) begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", n, e, s);
        end
    endtask : chk

    // one read with its answer pulse and byte checked
    task rchk(input reg_sel_t s, input logic [8:0] e, input logic [8:0] a);
        logic [7:0] d;
        logic       v;
        cpu.rd(s, d, v);
        chk("rd_valid", 9'h001, {8'h00, v});
        chk("rd_data", e, {1'b0, d});
        chk("cur_addr", a, cur_addr);
    endtask : rchk

    // fetch side shows memory one cycle after the address
    task fetch(input logic [8:0] a, input logic [8:0] c, input logic [7:0] o);
        disp_addr = a;
        repeat (2) @(negedge clock);
        chk("disp_code", c, disp_code);
        chk("disp_orn", {1'b0, o}, {1'b0, disp_orn});
    endtask : fetch

    task t_norm0();
        cpu.mode(1'b0, 1'b0, 1'b0);
        cpu.set_addr(9'h1FF);
        chk("cur_addr", 9'h1FF, cur_addr);
        cpu.wr(SEL_ORNAMENT, 8'hFF);
        chk("cur_addr", 9'h000, cur_addr);
        cpu.set_addr(9'h1FF);
        cpu.wr(SEL_CODE_MSB, 8'h01);
        cpu.wr(SEL_CODE_LOW, 8'h20);
        chk("cur_addr", 9'h000, cur_addr);
        cpu.wr(SEL_ORNAMENT, 8'hFF);
        chk("cur_addr", 9'h001, cur_addr);
        fetch(9'h1FF, 9'h120, 8'hF7);
        cpu.mode(1'b0, 1'b0, 1'b1);
        cpu.set_addr(9'h1FF);
        rchk(SEL_CODE_MSB, 9'h001, 9'h1FF);
        rchk(SEL_CODE_LOW, 9'h020, 9'h000);
        rchk(SEL_ORNAMENT, 9'h0F7, 9'h001);
    endtask : t_norm0

    task t_bank1();
        cpu.mode(1'b0, 1'b1, 1'b0);
        cpu.set_addr(9'h010);
        cpu.wr(SEL_ORNAMENT, 8'h15);
        chk("cur_addr", 9'h010, cur_addr);
        cpu.wr(SEL_CODE_LOW, 8'h33);
        chk("cur_addr", 9'h011, cur_addr);
        cpu.mode(1'b0, 1'b1, 1'b1);
        cpu.set_addr(9'h010);
        rchk(SEL_ORNAMENT, 9'h015, 9'h010);
        rchk(SEL_CODE_MSB, 9'h001, 9'h010);
        rchk(SEL_CODE_LOW, 9'h033, 9'h011);
    endtask : t_bank1

    task t_rmw();
        cpu.mode(1'b1, 1'b0, 1'b1);
        cpu.set_addr(9'h010);
        rchk(SEL_CODE_LOW, 9'h033, 9'h010);
        rchk(SEL_ORNAMENT, 9'h015, 9'h010);
        cpu.mode(1'b1, 1'b0, 1'b0);
        cpu.wr(SEL_ORNAMENT, 8'h07);
        chk("cur_addr", 9'h011, cur_addr);
        cpu.mode(1'b1, 1'b1, 1'b1);
        cpu.set_addr(9'h010);
        rchk(SEL_ORNAMENT, 9'h007, 9'h010);
        cpu.mode(1'b1, 1'b1, 1'b0);
        cpu.wr(SEL_ORNAMENT, 8'h0B);
        chk("cur_addr", 9'h010, cur_addr);
        cpu.wr(SEL_CODE_MSB, 8'h00);
        cpu.wr(SEL_CODE_LOW, 8'h44);
        chk("cur_addr", 9'h011, cur_addr);
        fetch(9'h010, 9'h044, 8'h03);
    endtask : t_rmw

    // refused strobes: wrong direction, and a write beating a read
    task t_refuse();
        logic v;
        cpu.mode(1'b0, 1'b0, 1'b0);
        cpu.set_addr(9'h020);
        rchk(SEL_CODE_LOW, 9'h000, 9'h020);
        cpu.both(SEL_CODE_LOW, 8'h5A, v);
        chk("rd_valid", 9'h000, {8'h00, v});
        chk("cur_addr", 9'h021, cur_addr);
        cpu.mode(1'b0, 1'b0, 1'b1);
        cpu.wr(SEL_CODE_LOW, 8'hA5);
        chk("cur_addr", 9'h021, cur_addr);
        cpu.set_addr(9'h020);
        rchk(SEL_CODE_LOW, 9'h05A, 9'h021);
    endtask : t_refuse

    initial begin
        rst = 1'b1;
        disp_addr = 9'h000;
        repeat (3) @(posedge clock);
        @(negedge clock);
        rst = 1'b0;
        chk("cur_addr", 9'h000, cur_addr);
        t_norm0();
        t_bank1();
        t_rmw();
        t_refuse();
        finish_test();
    end

    // a hang is cut short and counted
    initial begin
        repeat (20000) @(posedge clock);
        fail_count++;
        finish_test();
    end
endmodule : tb
